// *** verilog/sram_fifo_pkg.sv ***
// constants, port-width modes and helpers for the embedded memory/buffer block
// assumes one 100 MHz clock domain shared by all users of the block
package sram_fifo_pkg;
  localparam int unsigned MEM_BITS = 4608;
  localparam int unsigned BIT_ADDR_W = 13;
  localparam int unsigned WORD_ADDR_W = 12;
  localparam int unsigned MAX_WIDTH = 18;
  localparam int unsigned WIDTH_W = 5;
  localparam logic [BIT_ADDR_W-1:0] CAP_WIDE = 13'h1200;
  localparam logic [BIT_ADDR_W-1:0] CAP_NARROW = 13'h1000;
  localparam logic [BIT_ADDR_W-1:0] COUNT_RESET = 13'h0000;
  localparam logic [BIT_ADDR_W-1:0] PTR_RESET = 13'h0000;

  typedef enum logic [2:0] {
    MODE_4K_X1 = 3'b000,
    MODE_2K_X2 = 3'b001,
    MODE_1K_X4 = 3'b010,
    MODE_512_X9 = 3'b011,
    MODE_256_X18 = 3'b100
  } port_mode_t;

  function automatic logic [WIDTH_W-1:0] width_of(input port_mode_t m);
    case (m)
      MODE_2K_X2: width_of = 5'h02;
      MODE_1K_X4: width_of = 5'h04;
      MODE_512_X9: width_of = 5'h09;
      MODE_256_X18: width_of = 5'h12;
      default: width_of = 5'h01;
    endcase
  endfunction : width_of

  // the 9/18 organisations use the parity column, the others leave it idle
  function automatic logic [BIT_ADDR_W-1:0] cap_of(input port_mode_t m);
    cap_of = (m == MODE_512_X9 || m == MODE_256_X18) ? CAP_WIDE : CAP_NARROW;
  endfunction : cap_of
endpackage : sram_fifo_pkg

// *** verilog/mem_port_if.sv ***
// bit-addressed write and read port between the controller and the storage array
// assumes both ends share clock_in
`timescale 1ns/1ps
interface mem_port_if;
  import sram_fifo_pkg::*;
  logic wr_en;
  logic [BIT_ADDR_W-1:0] wr_base;
  logic [WIDTH_W-1:0] wr_width;
  logic [MAX_WIDTH-1:0] wr_data;
  logic rd_en;
  logic [BIT_ADDR_W-1:0] rd_base;
  logic [WIDTH_W-1:0] rd_width;
  logic [MAX_WIDTH-1:0] rd_data;
  modport ctrl (output wr_en, wr_base, wr_width, wr_data, rd_en, rd_base, rd_width, input rd_data);
  modport mem (input wr_en, wr_base, wr_width, wr_data, rd_en, rd_base, rd_width, output rd_data);
endinterface : mem_port_if

// *** verilog/bit_array_mem.sv ***
// 4608-bit storage array written and read in runs of 1 to 18 bits
// assumes callers keep base + width inside the array; read data is registered
`timescale 1ns/1ps
module bit_array_mem
  import sram_fifo_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  mem_port_if.mem port
);
  typedef struct packed {
    logic [MEM_BITS-1:0] bits;
    logic [MAX_WIDTH-1:0] rd_data;
  } mem_state_t;

  mem_state_t state_q;
  mem_state_t state_d;

  always_comb begin
    state_d = state_q;
    for (int i = 0; i < MAX_WIDTH; i++) begin
      if (port.wr_en && i < port.wr_width) begin
        state_d.bits[BIT_ADDR_W'(port.wr_base + BIT_ADDR_W'(i))] = port.wr_data[i];
      end
      if (port.rd_en) begin
        state_d.rd_data[i] = (i < port.rd_width) ? state_q.bits[BIT_ADDR_W'(port.rd_base + BIT_ADDR_W'(i))] : 1'b0;
      end
    end
    // contents survive reset so preloaded tables stay valid
    if (rst_in) begin
      state_d.rd_data = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    state_q <= state_d;
  end

  assign port.rd_data = state_q.rd_data;
endmodule : bit_array_mem

// *** verilog/sram_fifo_block.sv ***
// embedded memory block usable as dual-port RAM, preloaded table or synchronous buffer
// assumes user logic and test-port loader run on clock_in; config inputs held steady while in use
`timescale 1ns/1ps
module sram_fifo_block
  import sram_fifo_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic block_select_in,
  input wire logic buffer_mode_in,
  input wire port_mode_t wr_mode_in,
  input wire port_mode_t rd_mode_in,
  input wire logic [BIT_ADDR_W-1:0] near_empty_thresh_in,
  input wire logic [BIT_ADDR_W-1:0] near_full_thresh_in,
  input wire logic wr_en_in,
  input wire logic [WORD_ADDR_W-1:0] wr_addr_in,
  input wire logic [MAX_WIDTH-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [WORD_ADDR_W-1:0] rd_addr_in,
  input wire logic test_load_start_in,
  input wire logic test_load_valid_in,
  input wire logic test_load_bit_in,
  output logic [MAX_WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic wr_done_out,
  output logic empty_out,
  output logic full_out,
  output logic near_empty_flag_out,
  output logic near_full_flag_out
);
  typedef struct packed {
    logic [BIT_ADDR_W-1:0] wr_ptr;
    logic [BIT_ADDR_W-1:0] rd_ptr;
    logic [BIT_ADDR_W-1:0] count;
    logic [BIT_ADDR_W-1:0] load_ptr;
    logic rd_valid;
    logic wr_done;
    logic empty;
    logic full;
    logic near_empty;
    logic near_full;
  } ctrl_state_t;

  ctrl_state_t state_q;
  ctrl_state_t state_d;
  mem_port_if port ();

  logic [WIDTH_W-1:0] wr_w;
  logic [WIDTH_W-1:0] rd_w;
  logic [BIT_ADDR_W-1:0] cap;
  logic do_wr;
  logic do_rd;
  logic do_load;
  logic [BIT_ADDR_W+WIDTH_W-1:0] ne_level;
  logic [BIT_ADDR_W+WIDTH_W-1:0] nf_level;
  logic [BIT_ADDR_W-1:0] wr_bits;
  logic [BIT_ADDR_W-1:0] rd_bits;

  bit_array_mem u_mem (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .port(port)
  );

  // pointer step wraps at capacity c: the write organisation's for the buffer pointers, the whole array for the loader
  function automatic logic [BIT_ADDR_W-1:0] step(input logic [BIT_ADDR_W-1:0] p,
                                                 input logic [WIDTH_W-1:0] w,
                                                 input logic [BIT_ADDR_W-1:0] c);
    logic [BIT_ADDR_W-1:0] n;
    n = p + BIT_ADDR_W'(w);
    step = (n >= c) ? n - c : n;
  endfunction : step

  // address bits above the organisation's depth are ignored, so a stray
  // address folds back into the array instead of landing past its end
  function automatic logic [BIT_ADDR_W-1:0] word_base(input logic [WORD_ADDR_W-1:0] a,
                                                      input port_mode_t m);
    logic [WORD_ADDR_W-1:0] folded;
    folded = a;
    case (m)
      MODE_2K_X2: folded = a & 12'h7FF;
      MODE_1K_X4: folded = a & 12'h3FF;
      MODE_512_X9: folded = a & 12'h1FF;
      MODE_256_X18: folded = a & 12'h0FF;
      default: folded = a;
    endcase
    word_base = BIT_ADDR_W'(folded * width_of(m));
  endfunction : word_base

  always_comb begin
    wr_w = width_of(wr_mode_in);
    rd_w = width_of(rd_mode_in);
    cap = cap_of(wr_mode_in);
    // deselected block ignores both ports so several can share one bus
    do_load = test_load_valid_in;
    do_wr = block_select_in && wr_en_in && !do_load && !(buffer_mode_in && state_q.full);
    do_rd = block_select_in && rd_en_in && !(buffer_mode_in && state_q.empty);

    port.wr_en = do_load || do_wr;
    port.wr_width = do_load ? 5'h01 : wr_w;
    port.wr_data = do_load ? {{(MAX_WIDTH-1){1'b0}}, test_load_bit_in} : wr_data_in;
    port.rd_en = do_rd;
    port.rd_width = rd_w;
    // word address times port width gives the same bit order on both ports
    if (do_load) begin
      port.wr_base = state_q.load_ptr;
    end else if (buffer_mode_in) begin
      port.wr_base = state_q.wr_ptr;
    end else begin
      port.wr_base = word_base(wr_addr_in, wr_mode_in);
    end
    if (buffer_mode_in) begin
      port.rd_base = state_q.rd_ptr;
    end else begin
      port.rd_base = word_base(rd_addr_in, rd_mode_in);
    end

    // a refused request moves neither pointer nor count
    wr_bits = do_wr ? BIT_ADDR_W'(wr_w) : COUNT_RESET;
    rd_bits = do_rd ? BIT_ADDR_W'(rd_w) : COUNT_RESET;

    state_d = state_q;
    state_d.rd_valid = do_rd;
    state_d.wr_done = do_wr;
    if (test_load_start_in) begin
      state_d.load_ptr = PTR_RESET;
    end else if (do_load) begin
      state_d.load_ptr = step(state_q.load_ptr, 5'h01, BIT_ADDR_W'(MEM_BITS));
    end
    if (buffer_mode_in) begin
      if (do_wr) begin
        state_d.wr_ptr = step(state_q.wr_ptr, wr_w, cap);
      end
      if (do_rd) begin
        state_d.rd_ptr = step(state_q.rd_ptr, rd_w, cap);
      end
      state_d.count = state_q.count + wr_bits - rd_bits;
    end
    // count held in bits; thresholds are words of the matching port
    ne_level = (BIT_ADDR_W+WIDTH_W)'(near_empty_thresh_in * rd_w);
    nf_level = (BIT_ADDR_W+WIDTH_W)'(near_full_thresh_in * wr_w);
    // with unequal widths a partial word is neither readable nor room for a write
    state_d.empty = state_d.count < BIT_ADDR_W'(rd_w);
    state_d.full = (cap - state_d.count) < BIT_ADDR_W'(wr_w);
    state_d.near_empty = (BIT_ADDR_W+WIDTH_W)'(state_d.count) <= ne_level;
    state_d.near_full = (BIT_ADDR_W+WIDTH_W)'(state_d.count) >= nf_level;

    if (rst_in) begin
      state_d.wr_ptr = PTR_RESET;
      state_d.rd_ptr = PTR_RESET;
      state_d.count = COUNT_RESET;
      state_d.load_ptr = PTR_RESET;
      state_d.rd_valid = 1'b0;
      state_d.wr_done = 1'b0;
      state_d.empty = 1'b1;
      state_d.full = 1'b0;
      state_d.near_empty = 1'b1;
      state_d.near_full = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    state_q <= state_d;
  end

  assign rd_data_out = port.rd_data;
  assign rd_valid_out = state_q.rd_valid;
  assign wr_done_out = state_q.wr_done;
  assign empty_out = state_q.empty;
  assign full_out = state_q.full;
  assign near_empty_flag_out = state_q.near_empty;
  assign near_full_flag_out = state_q.near_full;
endmodule : sram_fifo_block

// *** tb/sram_fifo_monitor.sv ***
// port checker for sram_fifo_block
// assumes one clock, synchronous reset
`timescale 1ns/1ps
module sram_fifo_monitor
  import sram_fifo_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic block_select_in,
  input wire logic buffer_mode_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic test_load_valid_in,
  input wire logic [MAX_WIDTH-1:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic wr_done_out,
  input wire logic empty_out,
  input wire logic full_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_wr_take;
    wr_en_in && block_select_in && !test_load_valid_in;
  endsequence
  chk_wr_ack_ram: assert property (s_wr_take ##0 !buffer_mode_in |=> wr_done_out)
    else $error("write not acked");
  chk_wr_ack_cause: assert property (wr_done_out |-> $past(wr_en_in && block_select_in))
    else $error("stray write ack");
  chk_full_drop: assert property (buffer_mode_in && full_out && wr_en_in |=> !wr_done_out)
    else $error("write taken when full");
  chk_empty_drop: assert property (buffer_mode_in && empty_out && rd_en_in |=> !rd_valid_out && $stable(rd_data_out))
    else $error("read taken when empty");
  chk_rd_ack_ram: assert property (rd_en_in && block_select_in && !buffer_mode_in |=> rd_valid_out)
    else $error("read not answered");
  chk_rd_data_hold: assert property (!rd_valid_out |-> $stable(rd_data_out))
    else $error("read data moved");
  chk_flag_excl: assert property (!(empty_out && full_out))
    else $error("empty and full");
  chk_deselect_quiet: assert property (!block_select_in |=> !wr_done_out && !rd_valid_out)
    else $error("deselected block answered");
  chk_empty_leave: assert property (buffer_mode_in && $fell(empty_out) |-> wr_done_out)
    else $error("empty fell without write");
endmodule : sram_fifo_monitor
bind sram_fifo_block sram_fifo_monitor sram_fifo_monitor_inst (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .block_select_in(block_select_in),
  .buffer_mode_in(buffer_mode_in),
  .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in),
  .test_load_valid_in(test_load_valid_in),
  .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out),
  .wr_done_out(wr_done_out),
  .empty_out(empty_out),
  .full_out(full_out)
);

// *** tb/user_core_model.sv ***
// user core logic: one write or read request per call
// assumes calls come from one bench process
`timescale 1ns/1ps
module user_core_model
  import sram_fifo_pkg::*;
(
  input wire logic clock_in,
  output logic wr_en_out = 1'b0,
  output logic [MAX_WIDTH-1:0] wr_data_out = '0,
  output logic rd_en_out = 1'b0
);
  // released data inverted so a stale value never matches
  task put(input logic [MAX_WIDTH-1:0] d);
    @(negedge clock_in);
    wr_en_out <= 1'b1;
    wr_data_out <= d;
    @(negedge clock_in);
    wr_en_out <= 1'b0;
    wr_data_out <= ~d;
  endtask : put
  task get();
    @(negedge clock_in);
    rd_en_out <= 1'b1;
    @(negedge clock_in);
    rd_en_out <= 1'b0;
  endtask : get
endmodule : user_core_model

// *** tb/sram_fifo_block_bench.sv ***
// self-checking bench for sram_fifo_block
// assumes monitor bound, model drives user requests
`timescale 1ns/1ps
module sram_fifo_block_bench;
  import sram_fifo_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic block_select_in = 1'b1;
  logic buffer_mode_in = 1'b0;
  port_mode_t wr_mode_in = MODE_1K_X4;
  port_mode_t rd_mode_in = MODE_4K_X1;
  logic [12:0] near_empty_thresh_in = 13'h0001;
  logic [12:0] near_full_thresh_in = 13'h00FF;
  logic [11:0] wr_addr_in = 12'h002;
  logic [11:0] rd_addr_in = 12'h000;
  logic test_load_start_in = 1'b0;
  logic test_load_valid_in = 1'b0;
  logic test_load_bit_in = 1'b0;
  logic wr_en_in, rd_en_in, rd_valid_out, wr_done_out, empty_out, full_out;
  logic near_empty_flag_out, near_full_flag_out;
  logic [17:0] wr_data_in, rd_data_out;
  int bad_count = 0;
  int n_compared = 0;
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  sram_fifo_block sram_fifo_block_inst (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .block_select_in(block_select_in),
    .buffer_mode_in(buffer_mode_in),
    .wr_mode_in(wr_mode_in),
    .rd_mode_in(rd_mode_in),
    .near_empty_thresh_in(near_empty_thresh_in),
    .near_full_thresh_in(near_full_thresh_in),
    .wr_en_in(wr_en_in),
    .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in),
    .rd_en_in(rd_en_in),
    .rd_addr_in(rd_addr_in),
    .test_load_start_in(test_load_start_in),
    .test_load_valid_in(test_load_valid_in),
    .test_load_bit_in(test_load_bit_in),
    .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out),
    .wr_done_out(wr_done_out),
    .empty_out(empty_out),
    .full_out(full_out),
    .near_empty_flag_out(near_empty_flag_out),
    .near_full_flag_out(near_full_flag_out)
  );
  user_core_model user_core_model_inst (
    .clock_in(clock_in),
    .wr_en_out(wr_en_in),
    .wr_data_out(wr_data_in),
    .rd_en_out(rd_en_in)
  );
  task check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task do_reset();
    @(negedge clock_in);
    rst_in <= 1'b1;
    repeat (3) @(negedge clock_in);
    rst_in <= 1'b0;
  endtask : do_reset
  // x4 word at address 2 lands on bits 8..11
  task t_ram();
    block_select_in <= 1'b0;
    user_core_model_inst.put(18'h00006);
    check(wr_done_out, 1'b0);
    block_select_in <= 1'b1;
    user_core_model_inst.put(18'h00006);
    check(wr_done_out, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd_addr_in <= 12'(8 + i);
      user_core_model_inst.get();
      check(rd_data_out, {17'h0, i == 1 || i == 2});
    end
  endtask : t_ram
  task t_load();
    test_load_start_in <= 1'b1;
    @(negedge clock_in);
    test_load_start_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      test_load_valid_in <= 1'b1;
      test_load_bit_in <= (i != 1);
      @(negedge clock_in);
    end
    test_load_valid_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_addr_in <= 12'(i);
      user_core_model_inst.get();
      check(rd_data_out, {17'h0, i != 1});
    end
  endtask : t_load
  // x9 word at address 2 covers bits 18..26, x2 word at address 13 bits 26..27
  task t_modes();
    wr_mode_in <= MODE_512_X9;
    wr_addr_in <= 12'h002;
    user_core_model_inst.put(18'h000A5);
    check(wr_done_out, 1'b1);
    wr_mode_in <= MODE_2K_X2;
    wr_addr_in <= 12'h00D;
    user_core_model_inst.put(18'h00003);
    check(wr_done_out, 1'b1);
    rd_mode_in <= MODE_2K_X2;
    rd_addr_in <= 12'h009;
    user_core_model_inst.get();
    check({rd_valid_out, rd_data_out}, 19'h40001);
    rd_addr_in <= 12'h00C;
    user_core_model_inst.get();
    check({rd_valid_out, rd_data_out}, 19'h40002);
    rd_mode_in <= MODE_512_X9;
    rd_addr_in <= 12'h002;
    user_core_model_inst.get();
    check({rd_valid_out, rd_data_out}, 19'h401A5);
  endtask : t_modes
  // 256 x18 words fill 4608 bits; the 257th write and read are refused
  task t_fifo();
    buffer_mode_in <= 1'b1;
    wr_mode_in <= MODE_256_X18;
    rd_mode_in <= MODE_256_X18;
    do_reset();
    for (int i = 1; i <= 257; i++) begin
      user_core_model_inst.put(18'(i));
      check({wr_done_out, full_out, near_full_flag_out, near_empty_flag_out},
        {i < 257, i >= 256, i >= 255, i <= 1});
    end
    for (int i = 1; i <= 257; i++) begin
      user_core_model_inst.get();
      check({empty_out, near_empty_flag_out, rd_valid_out, rd_data_out},
        {i >= 256, i >= 255, i < 257, 18'(i < 257 ? i : 256)});
    end
  endtask : t_fifo
  initial begin
    do_reset();
    check({empty_out, full_out, near_empty_flag_out, near_full_flag_out, rd_valid_out, wr_done_out}, 6'h28);
    t_ram();
    t_load();
    t_modes();
    t_fifo();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    bad_count++;
    tally_and_finish();
  end
endmodule : sram_fifo_block_bench
